// ==== hdl/afc_trigger.sv ====
// Automatic flow-control trigger: watermark watch, pause request and jam
// Function
// - Any-frame mode with level reached jams on any received frame or requests a pause.
// - Full-duplex automatic flow control runs only with any-frame set in full duplex.
// - Half-duplex any-frame mode jams on next valid preamble, no address decode.
// - Full-duplex any-frame mode requests pause at once when level is reached.
// - Pause request stays pending until the transmitter takes it; only leaving full-duplex flow control aborts it.
// - Any-frame mode ignores multicast, broadcast and own-address selections.
// - Duration code picks jam length; 10 Mbps adds 2.2 us.
// - High watermark counts in 64-byte units of receive FIFO fill.
// - Back pressure lasts the coded period; code unused in full duplex.
// - No pause and no back pressure while the transmitter is disabled.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "afc_regs.svh"
module afc_trigger #(
    parameter int LEVEL_W = 15,
    parameter int CLK_PERIOD_NS = `AFC_CLK_PERIOD_NS,
    parameter int CNT_W = 17
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic [LEVEL_W-1:0] rx_fifo_level,
    input wire logic full_duplex,
    input wire logic speed_100,
    input wire logic tx_enable,
    input wire logic rx_preamble_valid,
    input wire logic rx_addr_valid,
    input wire logic rx_is_multicast,
    input wire logic rx_is_broadcast,
    input wire logic rx_is_own,
    output logic pause_request,
    input wire logic pause_ack,
    output logic back_pressure
);
    // ==========================================
    // Declarations
    logic [`FLOW_CONTROL_CONFIG_USED-1:0] cfg;
    afc_pkg::afc_pause_e state;
    afc_pkg::afc_pause_e next_state;
    logic wr_req;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_req;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    logic any_frame_trigger;
    logic multicast_trigger;
    logic broadcast_trigger;
    logic own_address_trigger;
    logic [7:0] high_watermark;
    logic [3:0] jam_duration_code;
    logic level_hit;
    logic fd_active;
    logic hd_active;
    logic sel_hit;
    logic frame_event;
    logic jam_start;
    logic jam_abort;
    logic [CNT_W-1:0] jam_count;

    if (LEVEL_W < 8 + `HIGH_WATERMARK_SHIFT) begin : g_bad_level
        $error("afc_trigger: LEVEL_W cannot hold the largest watermark");
    end
    if (CLK_PERIOD_NS < 1) begin : g_bad_period
        $error("afc_trigger: CLK_PERIOD_NS must be positive");
    end
    if (CNT_W < 17) begin : g_bad_cnt
        $error("afc_trigger: CNT_W cannot hold the longest jam");
    end

    // ==========================================
    // Jam length in clock cycles from code and speed
    function automatic logic [CNT_W-1:0] jam_cycles(input logic [3:0] code,
                                                    input logic fast);
        int us;
        int ns;
        case (code)
            4'h0: us = `AFC_JAM_US_0;
            4'h1: us = `AFC_JAM_US_1;
            4'h2: us = `AFC_JAM_US_2;
            4'h3: us = `AFC_JAM_US_3;
            4'h4: us = `AFC_JAM_US_4;
            default: us = `AFC_JAM_US_LONG + `AFC_JAM_US_STEP * (int'(code) - `AFC_JAM_LONG_CODE);
        endcase
        ns = us * `AFC_NS_PER_US + (fast ? 0 : `AFC_JAM_10M_EXTRA_NS);
        // Every entry is a whole number of 8 ns periods, so nothing is lost
        return CNT_W'(ns / CLK_PERIOD_NS);
    endfunction

    // ==========================================
    // Bus front end
    afc_axil_slave #(
        .ADDR_W(8)
    ) u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_req(wr_req),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_req(rd_req),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    // ==========================================
    // Registers
    assign wr_ok = (wr_addr == `AFC_ADDR_CFG) || (wr_addr == `AFC_ADDR_STAT);
    assign rd_ok = (rd_addr == `AFC_ADDR_CFG) || (rd_addr == `AFC_ADDR_STAT);

    // Top byte is reserved and stays zero; status writes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= `FLOW_CONTROL_CONFIG_USED'(`FLOW_CONTROL_CONFIG_RESET);
        end else if (wr_req && wr_addr == `AFC_ADDR_CFG) begin
            for (int b = 0; b < 3; b++) begin
                if (wr_strb[b]) begin
                    cfg[b*8 +: 8] <= wr_data[b*8 +: 8];
                end
            end
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (rd_addr == `AFC_ADDR_CFG) begin
            rd_data[`FLOW_CONTROL_CONFIG_USED-1:0] = cfg;
        end else if (rd_addr == `AFC_ADDR_STAT) begin
            rd_data[`AFC_ST_JAM_BIT] = back_pressure;
            rd_data[`AFC_ST_PAUSE_BIT] = pause_request;
            rd_data[`AFC_ST_HIT_BIT] = level_hit;
            rd_data[`AFC_ST_SENT_BIT] = (state == afc_pkg::AFC_SENT);
        end
    end

    assign any_frame_trigger = cfg[`AFC_ANY_BIT];
    assign multicast_trigger = cfg[`AFC_MULT_BIT];
    assign broadcast_trigger = cfg[`AFC_BRD_BIT];
    assign own_address_trigger = cfg[`AFC_ADD_BIT];
    assign high_watermark = cfg[`HIGH_WATERMARK_MSB:`HIGH_WATERMARK_LSB];
    assign jam_duration_code = cfg[`AFC_DUR_MSB:`AFC_DUR_LSB];

    // ==========================================
    // Trigger level
    assign level_hit = rx_fifo_level >= LEVEL_W'({high_watermark, 6'h00});

    // ==========================================
    // Full duplex: one pause request per crossing of the watermark
    assign fd_active = any_frame_trigger && full_duplex && tx_enable;

    always_comb begin
        next_state = state;
        case (state)
            afc_pkg::AFC_IDLE: begin
                if (fd_active && level_hit) begin
                    next_state = afc_pkg::AFC_PEND;
                end
            end
            afc_pkg::AFC_PEND: begin
                if (!fd_active) begin
                    next_state = afc_pkg::AFC_IDLE;
                end else if (pause_ack) begin
                    next_state = afc_pkg::AFC_SENT;
                end
            end
            afc_pkg::AFC_SENT: begin
                // Re-arms only after the level falls or full-duplex flow control drops, so a full FIFO sends one frame
                if (!fd_active || !level_hit) begin
                    next_state = afc_pkg::AFC_IDLE;
                end
            end
            default: next_state = afc_pkg::AFC_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= afc_pkg::AFC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign pause_request = (state == afc_pkg::AFC_PEND);

    // ==========================================
    // Half duplex: jam incoming frames
    assign hd_active = !full_duplex && tx_enable;
    assign sel_hit = (rx_is_multicast && multicast_trigger)
        || (rx_is_broadcast && broadcast_trigger)
        || (rx_is_own && own_address_trigger);
    // Any-frame mode looks only at the preamble, never at the address class
    assign frame_event = any_frame_trigger ? rx_preamble_valid
        : (rx_addr_valid && sel_hit);
    assign jam_start = hd_active && level_hit && frame_event;
    assign jam_abort = !hd_active;
    assign jam_count = jam_cycles(jam_duration_code, speed_100);

    afc_jam_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(jam_start),
        .load_count(jam_count),
        .abort(jam_abort),
        .busy(back_pressure)
    );

    // ==========================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_fd_needs_any: assert property ($rose(pause_request) |-> $past(fd_active))
        else $error("pause requested without any-frame full-duplex mode");
    a_fd_immediate: assert property (state == afc_pkg::AFC_IDLE && fd_active && level_hit
        |=> pause_request)
        else $error("pause not requested one cycle after level reached");
    a_pause_held: assert property (pause_request && !pause_ack && fd_active
        |=> pause_request)
        else $error("pending pause request dropped before it was taken");
    a_pause_once: assert property (pause_request && pause_ack |=> !pause_request)
        else $error("pause request repeated after it was taken");
    a_hd_preamble: assert property (hd_active && level_hit && any_frame_trigger
        && rx_preamble_valid && !back_pressure |=> back_pressure)
        else $error("preamble did not start back pressure");
    a_any_ignores_sel: assert property ($rose(back_pressure) && $past(any_frame_trigger)
        |-> $past(rx_preamble_valid))
        else $error("address class started a jam in any-frame mode");
    a_jam_hd_only: assert property (back_pressure |-> $past(hd_active))
        else $error("back pressure while full duplex or transmitter off");
    a_txoff_quiet: assert property (!tx_enable |=> !pause_request && !back_pressure)
        else $error("flow control active with transmitter disabled");
    a_level_units: assert property ($rose(back_pressure)
        |-> 32'($past(rx_fifo_level)) >= 32'($past(high_watermark)) * 64)
        else $error("jam started below the watermark");

    c_pause_taken: cover property (pause_request && pause_ack);
    c_jam_preamble: cover property (jam_start && any_frame_trigger);
    c_jam_address: cover property (jam_start && !any_frame_trigger);
    c_jam_end: cover property ($fell(back_pressure) && hd_active);
endmodule

// ==== hdl/afc_regs.svh ====
// Register map, field positions, reset values and timing constants of the flow-control trigger
`ifndef AFC_REGS_SVH
`define AFC_REGS_SVH

// ==========================================
// Register offsets (byte addresses)
`define AFC_ADDR_CFG 8'hAC
`define AFC_ADDR_STAT 8'hB8

// ==========================================
// Configuration fields
`define FLOW_CONTROL_CONFIG_RESET 32'h0000_0000
`define FLOW_CONTROL_CONFIG_USED 24
`define HIGH_WATERMARK_MSB 23
`define HIGH_WATERMARK_LSB 16
`define AFC_LO_MSB 15
`define AFC_LO_LSB 8
`define AFC_DUR_MSB 7
`define AFC_DUR_LSB 4
`define AFC_MULT_BIT 3
`define AFC_BRD_BIT 2
`define AFC_ADD_BIT 1
`define AFC_ANY_BIT 0

// Watermark unit is 64 bytes
`define HIGH_WATERMARK_SHIFT 6

// ==========================================
// Status fields
`define AFC_ST_JAM_BIT 0
`define AFC_ST_PAUSE_BIT 1
`define AFC_ST_HIT_BIT 2
`define AFC_ST_SENT_BIT 3

// ==========================================
// Jam durations in microseconds and the 10 Mbps extra in nanoseconds
`define AFC_JAM_US_0 5
`define AFC_JAM_US_1 10
`define AFC_JAM_US_2 15
`define AFC_JAM_US_3 25
`define AFC_JAM_US_4 50
`define AFC_JAM_US_LONG 100
`define AFC_JAM_US_STEP 50
`define AFC_JAM_LONG_CODE 5
`define AFC_JAM_10M_EXTRA_NS 2200
`define AFC_NS_PER_US 1000
`define AFC_CLK_PERIOD_NS 8

`endif

// ==== hdl/afc_pkg.sv ====
// Types shared by the flow-control trigger modules
package afc_pkg;
    typedef enum logic [1:0] {
        AFC_IDLE = 2'b00,
        AFC_PEND = 2'b01,
        AFC_SENT = 2'b10
    } afc_pause_e;

    typedef enum logic [1:0] {
        AFC_OKAY = 2'b00,
        AFC_SLVERR = 2'b10
    } afc_resp_e;
endpackage

// ==== hdl/afc_jam_timer.sv ====
// Back-pressure duration counter
`timescale 1ns/1ns
module afc_jam_timer #(
    parameter int CNT_W = 17
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_count,
    input wire logic abort,
    output logic busy
);
    logic [CNT_W-1:0] remaining;

    if (CNT_W < 2) begin : g_bad_width
        $error("afc_jam_timer: CNT_W too small");
    end

    // ==========================================
    // Counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy <= 1'b0;
            remaining <= '0;
        end else if (abort) begin
            busy <= 1'b0;
            remaining <= '0;
        end else if (load && !busy) begin
            busy <= 1'b1;
            remaining <= load_count;
        end else if (busy) begin
            if (remaining <= CNT_W'(1)) begin
                busy <= 1'b0;
            end
            remaining <= remaining - CNT_W'(1);
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_timer_load: assert property (load && !busy && !abort |=> busy && remaining == $past(load_count))
        else $error("jam timer did not load its count");
    a_timer_expire: assert property (busy && remaining == CNT_W'(1) && !abort |=> !busy)
        else $error("jam did not end when its count ran out");
endmodule

// ==== hdl/afc_axil_slave.sv ====
// AXI4-Lite slave front end: single outstanding write and read
`timescale 1ns/1ns
module afc_axil_slave #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic wr_req,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_req,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);
    logic aw_full;
    logic w_full;

    // ==========================================
    // Write path: address and data taken in either order
    assign s_awready = !aw_full;
    assign s_wready = !w_full;
    assign wr_req = aw_full && w_full && !s_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            wr_addr <= '0;
        end else if (s_awvalid && s_awready) begin
            aw_full <= 1'b1;
            wr_addr <= s_awaddr;
        end else if (wr_req) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (s_wvalid && s_wready) begin
            w_full <= 1'b1;
            wr_data <= s_wdata;
            wr_strb <= s_wstrb;
        end else if (wr_req) begin
            w_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_bvalid <= 1'b0;
            s_bresp <= afc_pkg::AFC_OKAY;
        end else if (wr_req) begin
            s_bvalid <= 1'b1;
            s_bresp <= wr_ok ? afc_pkg::AFC_OKAY : afc_pkg::AFC_SLVERR;
        end else if (s_bready) begin
            s_bvalid <= 1'b0;
        end
    end

    // ==========================================
    // Read path: data registered one cycle after the address
    assign s_arready = !s_rvalid;
    assign rd_req = s_arvalid && s_arready;
    assign rd_addr = s_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= afc_pkg::AFC_OKAY;
        end else if (rd_req) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_ok ? rd_data : 32'h0000_0000;
            s_rresp <= rd_ok ? afc_pkg::AFC_OKAY : afc_pkg::AFC_SLVERR;
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule

// ==== dv/afc_mac_model.sv ====
// Behavioural model of the MAC transmitter side that takes pause requests
`timescale 1ns/1ns
module afc_mac_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pause_request,
    input wire logic tx_busy,
    output logic pause_ack,
    output logic [7:0] pause_sent
);
    // ==========================================
    // Pause frame queue
    // A frame already on the wire is never cut short, so the pause waits for tx_busy to drop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_ack <= 1'b0;
        end else begin
            pause_ack <= pause_request && !pause_ack && !tx_busy;
        end
    end

    // Count of pause frames actually sent
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_sent <= 8'h00;
        end else if (pause_ack && pause_request) begin
            pause_sent <= pause_sent + 8'h01;
        end
    end
endmodule

// ==== dv/auto_flow_control_trigger_tb_top.sv ====
// Self-checking testbench for the automatic flow-control trigger
`timescale 1ns/1ns
`include "afc_regs.svh"
module auto_flow_control_trigger_tb_top;
    // ==========================================
    // Signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [14:0] level = 15'h0000;
    logic fd = 1'b0;
    logic fast = 1'b1;
    logic tx_en = 1'b0;
    logic pre = 1'b0;
    logic addr_v = 1'b0;
    logic [2:0] cls = 3'h0;
    logic tx_busy = 1'b0;
    logic pause_req, pause_ack, back_pressure;
    logic [7:0] sent;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;

    always #4 aclk = ~aclk;

    // Jams shortened: one clock stands for 200 ns
    afc_trigger #(.LEVEL_W(15), .CLK_PERIOD_NS(200), .CNT_W(17)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
        .rx_fifo_level(level), .full_duplex(fd), .speed_100(fast), .tx_enable(tx_en),
        .rx_preamble_valid(pre), .rx_addr_valid(addr_v), .rx_is_multicast(cls[2]),
        .rx_is_broadcast(cls[1]), .rx_is_own(cls[0]),
        .pause_request(pause_req), .pause_ack(pause_ack), .back_pressure(back_pressure)
    );

    afc_mac_model u_mac (
        .aclk(aclk), .aresetn(aresetn), .pause_request(pause_req), .tx_busy(tx_busy),
        .pause_ack(pause_ack), .pause_sent(sent)
    );

    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic ticks(input int k);
        repeat (k) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p, w_p, aw_t, w_t, got;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw_p = 1'b1;
        w_p = 1'b1;
        // Ready is looked at before the edge so the release lands right after it
        do begin
            @(negedge aclk);
            aw_t = aw_p & awready;
            w_t = w_p & wready;
            @(posedge aclk);
            if (aw_t === 1'b1) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_t === 1'b1) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end while (aw_p | w_p);
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            got = bvalid;
            resp = bresp;
            @(posedge aclk);
        end while (got !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        logic got;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            got = arready;
            @(posedge aclk);
        end while (got !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            got = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
        end while (got !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic cfg(input logic [7:0] hi, input logic [3:0] code, input logic [3:0] sel);
        axi_wr(`AFC_ADDR_CFG, {8'h00, hi, 8'h00, code, sel});
    endtask

    // One received frame event: a preamble, or a decoded address of class c
    task automatic pulse(input logic p, input logic [2:0] c);
        @(posedge aclk);
        pre <= p;
        addr_v <= !p;
        cls <= c;
        @(posedge aclk);
        pre <= 1'b0;
        addr_v <= 1'b0;
        cls <= 3'h0;
    endtask

    task automatic measure();
        @(negedge aclk);
        n = 0;
        while (back_pressure === 1'b1 && n < 4000) begin
            n++;
            @(negedge aclk);
        end
    endtask

    function automatic int exp_jam(input int code, input logic f);
        int tbl[5] = '{5, 10, 15, 25, 50};
        int us;
        us = (code < 5) ? tbl[code] : 100 + 50 * (code - 5);
        return (us * 1000 + (f ? 0 : 2200)) / 200;
    endfunction

    // ==========================================
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        ticks(8);
        aresetn <= 1'b1;
        check({30'h0, pause_req, back_pressure}, 32'h0, "outputs after reset");
        axi_rd(`AFC_ADDR_CFG);
        check(rd, 32'h0, "config reset value");
        axi_wr(`AFC_ADDR_CFG, 32'hFFFF_FFFF);
        axi_rd(`AFC_ADDR_CFG);
        check(rd, 32'h00FF_FFFF, "config readback");
        axi_rd(8'h10);
        check({resp, rd[29:0]}, 32'h8000_0000, "unmapped read");
        axi_wr(8'h10, 32'h1);
        check({30'h0, resp}, 32'h2, "unmapped write");
        axi_wr(`AFC_ADDR_STAT, 32'hF);
        check({30'h0, resp}, 32'h0, "status write");
        // Full duplex: watermark of 2 means 128 bytes
        cfg(8'h02, 4'h0, 4'h1);
        fd <= 1'b1;
        tx_en <= 1'b1;
        tx_busy <= 1'b1;
        level <= 15'd127;
        ticks(6);
        check({31'h0, pause_req}, 32'h0, "pause below level");
        level <= 15'd128;
        ticks(1);
        @(negedge aclk);
        check({31'h0, pause_req}, 32'h1, "pause at level");
        pulse(1'b1, 3'h0);
        measure();
        check(n, 0, "jam in full duplex");
        ticks(10);
        check({24'h0, sent}, 32'h0, "pause held while busy");
        axi_rd(`AFC_ADDR_STAT);
        check(rd & 32'hF, 32'h6, "status pending");
        tx_busy <= 1'b0;
        ticks(25);
        check({23'h0, sent, pause_req}, 32'h2, "single pause sent");
        axi_rd(`AFC_ADDR_STAT);
        check(rd & 32'hF, 32'hC, "status sent");
        level <= 15'd0;
        ticks(3);
        level <= 15'd128;
        ticks(8);
        check({24'h0, sent}, 32'h2, "pause after re-arm");
        // Without any-frame mode full duplex sends nothing
        level <= 15'd0;
        cfg(8'h02, 4'h0, 4'hE);
        level <= 15'd128;
        ticks(8);
        check({23'h0, sent, pause_req}, 32'h4, "no pause without any-frame");
        level <= 15'd0;
        tx_en <= 1'b0;
        cfg(8'h02, 4'h0, 4'h1);
        level <= 15'd128;
        ticks(8);
        check({23'h0, sent, pause_req}, 32'h4, "no pause with tx off");
        // Half duplex
        fd <= 1'b0;
        pulse(1'b1, 3'h0);
        measure();
        check(n, 0, "no jam with tx off");
        tx_en <= 1'b1;
        level <= 15'd127;
        pulse(1'b1, 3'h0);
        measure();
        check(n, 0, "no jam below level");
        level <= 15'd128;
        cfg(8'h02, 4'h0, 4'hF);
        pulse(1'b0, 3'h7);
        measure();
        check(n, 0, "class ignored in any-frame");
        pulse(1'b1, 3'h0);
        measure();
        check(n, exp_jam(0, 1'b1), "jam on preamble");
        for (int i = 0; i < 3; i++) begin
            cfg(8'h02, 4'h0, 4'h8 >> i);
            pulse(1'b0, 3'h4 >> i);
            measure();
            check(n, exp_jam(0, 1'b1), "jam on selected class");
        end
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 16; c++) begin
                fast <= f[0];
                cfg(8'h02, c[3:0], 4'h1);
                pulse(1'b1, 3'h0);
                measure();
                check(n, exp_jam(c, f[0]), "jam length");
            end
        end
        // Jam cut short when the transmitter is switched off
        cfg(8'h02, 4'hF, 4'h1);
        pulse(1'b1, 3'h0);
        ticks(10);
        tx_en <= 1'b0;
        ticks(1);
        @(negedge aclk);
        check({31'h0, back_pressure}, 32'h0, "jam ends with tx off");
        ticks(5);
        give_verdict();
    end
endmodule
